// ---- hw/arbl_pkg.sv ----
// Package for the abort/reset button and status indicator block.
// Assumes a single 10 MHz board clock.
package arbl_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned HOLD_SEC = 5;
  localparam int unsigned HOLD_CYC = HOLD_SEC * CLK_HZ;
  localparam int unsigned DEB_US = 10_000;
  localparam int unsigned DEB_CYC = (DEB_US * (CLK_HZ / 1_000_000));
  localparam int unsigned RST_PULSE_US = 1_000;
  localparam int unsigned RST_CYC = RST_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SLOW_BLINK_CYC = 5_000_000;
  localparam int unsigned FAST_BLINK_CYC = 1_000_000;
  localparam int unsigned ACT_BLINK_CYC = 500_000;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam logic [3:0] ADDR_MASK = 4'h2;
  localparam logic [3:0] ADDR_LINK = 4'h3;

  localparam int unsigned CTRL_FAIL = 0;
  localparam int unsigned CTRL_USER0 = 1;
  localparam int unsigned CTRL_DPA = 4;
  localparam int unsigned CTRL_SYSCON = 5;
  localparam logic [7:0] CTRL_RST = 8'h01;

  localparam int unsigned EV_ABORT = 0;
  localparam int unsigned EV_PWRFAIL = 1;
  localparam int unsigned EV_W = 2;

  // Link speed codes
  localparam logic [1:0] SPD_NONE = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;

  // Link quality codes
  localparam logic [1:0] LQ_NONE = 2'h0;
  localparam logic [1:0] LQ_POOR = 2'h1;
  localparam logic [1:0] LQ_FAIR = 2'h2;
  localparam logic [1:0] LQ_GOOD = 2'h3;

  typedef enum logic [1:0] {
    ARBL_IDLE,
    ARBL_PRESS,
    ARBL_HELD,
    ARBL_RESET
  } arbl_state_t;

endpackage : arbl_pkg

// ---- hw/arbl_blinker.sv ----
// Blink generator: free-running toggle with a given half period.
// Assumes the board clock and reset of the enclosing block.
`timescale 1ns/1ps
module arbl_blinker #(
  parameter int unsigned HALF_CYC = 1
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Output
  output logic o_blink
);

  typedef struct packed {
    logic [23:0] cnt;
    logic blink;
  } arbl_blk_t;

  arbl_blk_t s_r;
  arbl_blk_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (s_r.cnt >= 24'(HALF_CYC - 1)) begin
      s_nxt.cnt = '0;
      s_nxt.blink = ~s_r.blink;
    end else begin
      s_nxt.cnt = s_r.cnt + 24'h000001;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_blink = s_r.blink;

endmodule : arbl_blinker

// ---- hw/arbl_top.sv ----
// Abort/reset button timer and board status indicator drive.
// Assumes one 10 MHz board clock, button input synchronous to it,
// and a simple strobe register port with read data one cycle later.
//
// Summary of operation
// - Short press release raises abort interrupt only
// - Press held over five seconds: hard reset
// - Hard reset hits processor, buses, PHYs, flash
// - System controller also resets VME bus, bridge
// - Fail LED on after reset until cleared
// - User LEDs follow their own control bits
// - Speed LED off, yellow, green by speed
// - Activity LED blinks with traffic, else off
// - Link quality LED blinks by noise level
// - Storage LED A: either port or port 0
// - Storage LED B: port 1 in dual mode
// - Ready LED lit by processor ready or trigger output
// - Power fail LED follows failure signal
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module arbl_top #(
  parameter int unsigned HOLD_CYC = arbl_pkg::HOLD_CYC,
  parameter int unsigned DEB_CYC = arbl_pkg::DEB_CYC
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Button, pressed high
  input wire logic i_abort_reset_button,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Status inputs
  input wire logic [1:0] i_speed_g1,
  input wire logic [1:0] i_speed_g2,
  input wire logic i_link_f1,
  input wire logic [2:0] i_activity,
  input wire logic [1:0] i_quality_g1,
  input wire logic [1:0] i_quality_g2,
  input wire logic [1:0] i_storage_act,
  input wire logic i_cpu_ready,
  input wire logic i_trigger_output,
  input wire logic i_power_fail,
  // Interrupt and resets, active high
  output logic o_irq,
  output logic o_abort_irq,
  output logic o_board_reset,
  output logic o_vme_reset,
  // Indicators, high means lit
  output logic o_fail_led,
  output logic [2:0] o_user_led,
  output logic [2:0] o_speed_yellow_led,
  output logic [1:0] o_speed_green_led,
  output logic [2:0] o_link_activity_led,
  output logic [1:0] o_link_quality_led,
  output logic o_storage_activity_led_a,
  output logic o_storage_activity_led_b,
  output logic o_processor_ready_led,
  output logic o_power_fail_led
);

  typedef struct packed {
    arbl_pkg::arbl_state_t st;
    logic [25:0] hold_cnt;
    logic [17:0] deb_cnt;
    logic btn_deb;
    logic [13:0] rst_cnt;
    logic [7:0] ctrl;
    logic [arbl_pkg::EV_W-1:0] stat;
    logic [arbl_pkg::EV_W-1:0] mask;
    logic pwr_q;
    logic [7:0] rdata;
    logic irq;
    logic abort_irq;
    logic board_reset;
    logic vme_reset;
    logic fail_led;
    logic [2:0] user_led;
    logic [2:0] spd_y;
    logic [1:0] spd_g;
    logic [2:0] act_led;
    logic [1:0] lq_led;
    logic sta_a;
    logic sta_b;
    logic rdy_led;
    logic pf_led;
  } arbl_top_t;

  arbl_top_t s_r;
  arbl_top_t s_nxt;
  logic slow_blk;
  logic fast_blk;
  logic act_blk;

  arbl_blinker #(.HALF_CYC(arbl_pkg::SLOW_BLINK_CYC)) u_slow (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .o_blink(slow_blk)
  );
  arbl_blinker #(.HALF_CYC(arbl_pkg::FAST_BLINK_CYC)) u_fast (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .o_blink(fast_blk)
  );
  arbl_blinker #(.HALF_CYC(arbl_pkg::ACT_BLINK_CYC)) u_act (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .o_blink(act_blk)
  );

  logic [1:0] spd [3];
  logic [1:0] lq [2];
  logic [arbl_pkg::EV_W-1:0] ev;
  logic abort_ev;
  logic hard_rst;

  always_comb begin
    spd[0] = i_speed_g1;
    spd[1] = i_speed_g2;
    spd[2] = i_link_f1 ? arbl_pkg::SPD_100 : arbl_pkg::SPD_NONE;
    lq[0] = i_quality_g1;
    lq[1] = i_quality_g2;
  end

  always_comb begin
    s_nxt = s_r;
    abort_ev = 1'b0;
    hard_rst = 1'b0;
    if (i_abort_reset_button != s_r.btn_deb) begin
      if (s_r.deb_cnt >= 18'(DEB_CYC - 1)) begin
        s_nxt.btn_deb = i_abort_reset_button;
        s_nxt.deb_cnt = '0;
      end else begin
        s_nxt.deb_cnt = s_r.deb_cnt + 18'h00001;
      end
    end else begin
      s_nxt.deb_cnt = '0;
    end
    unique case (s_r.st)
      arbl_pkg::ARBL_IDLE: begin
        s_nxt.hold_cnt = '0;
        if (s_r.btn_deb) begin
          s_nxt.st = arbl_pkg::ARBL_PRESS;
        end
      end
      arbl_pkg::ARBL_PRESS: begin
        if (!s_r.btn_deb) begin
          abort_ev = 1'b1;
          s_nxt.st = arbl_pkg::ARBL_IDLE;
        end else if (s_r.hold_cnt >= 26'(HOLD_CYC - 1)) begin
          s_nxt.st = arbl_pkg::ARBL_RESET;
          s_nxt.rst_cnt = '0;
        end else begin
          s_nxt.hold_cnt = s_r.hold_cnt + 26'h0000001;
        end
      end
      arbl_pkg::ARBL_RESET: begin
        hard_rst = 1'b1;
        if (s_r.rst_cnt >= 14'(arbl_pkg::RST_CYC - 1)) begin
          s_nxt.st = arbl_pkg::ARBL_HELD;
        end else begin
          s_nxt.rst_cnt = s_r.rst_cnt + 14'h0001;
        end
      end
      arbl_pkg::ARBL_HELD: begin
        if (!s_r.btn_deb) begin
          s_nxt.st = arbl_pkg::ARBL_IDLE;
        end
      end
    endcase
    s_nxt.board_reset = hard_rst;
    s_nxt.vme_reset = hard_rst & s_r.ctrl[arbl_pkg::CTRL_SYSCON];
    s_nxt.abort_irq = abort_ev;
    ev = '0;
    ev[arbl_pkg::EV_ABORT] = abort_ev;
    ev[arbl_pkg::EV_PWRFAIL] = i_power_fail & ~s_r.pwr_q;
    s_nxt.pwr_q = i_power_fail;
    // Register port; read of status clears, new events win
    s_nxt.rdata = '0;
    if (i_wr) begin
      if (i_addr == arbl_pkg::ADDR_CTRL) begin
        s_nxt.ctrl = i_wdata;
      end else if (i_addr == arbl_pkg::ADDR_MASK) begin
        s_nxt.mask = i_wdata[arbl_pkg::EV_W-1:0];
      end
    end
    if (i_rd) begin
      unique case (i_addr)
        arbl_pkg::ADDR_CTRL: s_nxt.rdata = s_r.ctrl;
        arbl_pkg::ADDR_STAT: s_nxt.rdata = {6'h00, s_r.stat};
        arbl_pkg::ADDR_MASK: s_nxt.rdata = {6'h00, s_r.mask};
        arbl_pkg::ADDR_LINK: s_nxt.rdata = {i_quality_g1, i_speed_g2,
                                            i_speed_g1, 1'b0, s_r.btn_deb};
        default: s_nxt.rdata = '0;
      endcase
    end
    if (i_rd && i_addr == arbl_pkg::ADDR_STAT) begin
      s_nxt.stat = ev;
    end else begin
      s_nxt.stat = s_r.stat | ev;
    end
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
    // Reload as the pulse ends, so the controller bit holds the bus reset
    if (hard_rst && s_nxt.st == arbl_pkg::ARBL_HELD) begin
      // Fail LED back on after reset
      s_nxt.ctrl = arbl_pkg::CTRL_RST;
    end
    s_nxt.fail_led = s_nxt.ctrl[arbl_pkg::CTRL_FAIL];
    s_nxt.user_led = s_nxt.ctrl[arbl_pkg::CTRL_USER0 +: 3];
    for (int i = 0; i < 3; i++) begin
      s_nxt.spd_y[i] = (spd[i] == arbl_pkg::SPD_100);
      s_nxt.act_led[i] = i_activity[i] & act_blk;
    end
    for (int i = 0; i < 2; i++) begin
      s_nxt.spd_g[i] = (spd[i] == arbl_pkg::SPD_1000);
      unique case (lq[i])
        arbl_pkg::LQ_NONE: s_nxt.lq_led[i] = 1'b0;
        arbl_pkg::LQ_POOR: s_nxt.lq_led[i] = slow_blk;
        arbl_pkg::LQ_FAIR: s_nxt.lq_led[i] = fast_blk;
        arbl_pkg::LQ_GOOD: s_nxt.lq_led[i] = 1'b1;
      endcase
    end
    s_nxt.sta_a = s_r.ctrl[arbl_pkg::CTRL_DPA] ? i_storage_act[0]
                                               : |i_storage_act;
    // Storage B only in dual mode
    s_nxt.sta_b = s_r.ctrl[arbl_pkg::CTRL_DPA] & i_storage_act[1];
    s_nxt.rdy_led = i_cpu_ready | i_trigger_output;
    s_nxt.pf_led = i_power_fail;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
      s_r.ctrl <= arbl_pkg::CTRL_RST;
      s_r.fail_led <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rdata = s_r.rdata;
  assign o_irq = s_r.irq;
  assign o_abort_irq = s_r.abort_irq;
  assign o_board_reset = s_r.board_reset;
  assign o_vme_reset = s_r.vme_reset;
  assign o_fail_led = s_r.fail_led;
  assign o_user_led = s_r.user_led;
  assign o_speed_yellow_led = s_r.spd_y;
  assign o_speed_green_led = s_r.spd_g;
  assign o_link_activity_led = s_r.act_led;
  assign o_link_quality_led = s_r.lq_led;
  assign o_storage_activity_led_a = s_r.sta_a;
  assign o_storage_activity_led_b = s_r.sta_b;
  assign o_processor_ready_led = s_r.rdy_led;
  assign o_power_fail_led = s_r.pf_led;

  property p_short_abort;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (s_r.st == arbl_pkg::ARBL_PRESS && !s_r.btn_deb)
      |=> o_abort_irq && !o_board_reset;
  endproperty
  a_short_abort: assert property (p_short_abort)
    else $error("short press did not abort");

  property p_long_reset;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (s_r.st == arbl_pkg::ARBL_PRESS && s_r.btn_deb
       && s_r.hold_cnt >= 26'(HOLD_CYC - 1)) |=> ##1 o_board_reset;
  endproperty
  a_long_reset: assert property (p_long_reset)
    else $error("long press did not reset");

  property p_reset_len;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(o_board_reset) |-> o_board_reset [*8];
  endproperty
  a_reset_len: assert property (p_reset_len)
    else $error("board reset too short");

  property p_vme;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_vme_reset |-> o_board_reset;
  endproperty
  a_vme: assert property (p_vme)
    else $error("vme reset without board reset");

  property p_fail_after;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $fell(o_board_reset) |-> o_fail_led;
  endproperty
  a_fail_after: assert property (p_fail_after)
    else $error("fail led off after reset");

  property p_user;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_wr && i_addr == arbl_pkg::ADDR_CTRL && !hard_rst) |=>
      o_user_led == $past(i_wdata[arbl_pkg::CTRL_USER0 +: 3]);
  endproperty
  a_user: assert property (p_user)
    else $error("user led mismatch");

  property p_no_green_fast;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_speed_green_led[0] |-> !o_speed_yellow_led[0];
  endproperty
  a_no_green_fast: assert property (p_no_green_fast)
    else $error("speed led both colours");

  property p_sta_b;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_storage_activity_led_b |-> $past(s_r.ctrl[arbl_pkg::CTRL_DPA]);
  endproperty
  a_sta_b: assert property (p_sta_b)
    else $error("storage led b lit in legacy mode");

  property p_pf;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_power_fail |=> o_power_fail_led;
  endproperty
  a_pf: assert property (p_pf)
    else $error("power fail led not lit");

  c_abort: cover property (@(posedge i_clk_sys) $rose(o_abort_irq));
  c_reset: cover property (@(posedge i_clk_sys) $rose(o_board_reset));
  c_irq: cover property (@(posedge i_clk_sys) $rose(o_irq));

endmodule : arbl_top

// ---- dv/arbl_btn_model.sv ----
// Operator push button model with contact bounce at make.
// Assumes the bench pulses i_go for one cycle and holds i_len.
`timescale 1ns/1ps
module arbl_btn_model (
  // Clock
  input wire logic i_clk_sys,
  // Control from the bench
  input wire logic i_go,
  input wire logic [15:0] i_len,
  // Button, high while pressed
  output logic o_button
);
  int cnt = 0;
  always @(posedge i_clk_sys) begin
    if (i_go) begin
      cnt <= i_len + 3;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  always @(posedge i_clk_sys) begin
    o_button <= (cnt > 0) && (cnt != i_len + 2);
  end
endmodule : arbl_btn_model

// ---- dv/testbench.sv ----
// Bench for the abort/reset button timer and status indicators.
// Assumes arbl_top with shortened hold and debounce counts.
`timescale 1ns/1ps
module testbench;
  localparam int HOLD = 200;
  logic i_clk_sys, i_rst_n, i_wr, i_rd, i_link_f1, i_cpu_ready, go;
  logic i_trigger_output, i_power_fail, i_abort_reset_button;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata;
  logic [1:0] i_speed_g1, i_speed_g2, i_quality_g1, i_quality_g2;
  logic [1:0] i_storage_act, o_speed_green_led, o_link_quality_led;
  logic [2:0] i_activity, o_user_led, o_speed_yellow_led;
  logic [2:0] o_link_activity_led;
  logic o_irq, o_abort_irq, o_board_reset, o_vme_reset, o_fail_led;
  logic o_storage_activity_led_a, o_storage_activity_led_b;
  logic o_processor_ready_led, o_power_fail_led;
  logic [15:0] len;
  logic [1:0] s;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_abort = 0;
  int k;

  arbl_top #(.HOLD_CYC(HOLD), .DEB_CYC(4)) dut (.i_clk_sys, .i_rst_n,
    .i_abort_reset_button, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_speed_g1, .i_speed_g2, .i_link_f1, .i_activity, .i_quality_g1,
    .i_quality_g2, .i_storage_act, .i_cpu_ready, .i_trigger_output,
    .i_power_fail, .o_irq, .o_abort_irq, .o_board_reset, .o_vme_reset,
    .o_fail_led, .o_user_led, .o_speed_yellow_led, .o_speed_green_led,
    .o_link_activity_led, .o_link_quality_led, .o_storage_activity_led_a,
    .o_storage_activity_led_b, .o_processor_ready_led, .o_power_fail_led);
  arbl_btn_model btn (.i_clk_sys, .i_go(go), .i_len(len),
    .o_button(i_abort_reset_button));

  always #50 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    if (o_abort_irq === 1'b1) begin
      n_abort++;
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : step

  task automatic chk(input logic [15:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp, "read data");
  endtask : rdchk

  task automatic press(input logic [15:0] n);
    @(posedge i_clk_sys);
    len <= n;
    go <= 1'b1;
    @(posedge i_clk_sys);
    go <= 1'b0;
  endtask : press

  task automatic long_press(input logic [7:0] ctrl, input logic vme);
    int w;
    int a0;
    int v;
    a0 = n_abort;
    wr(arbl_pkg::ADDR_CTRL, ctrl);
    press(16'(HOLD + 60));
    w = 0;
    while (o_board_reset !== 1'b1 && w < HOLD + 100) begin
      step(1);
      w++;
    end
    chk(o_board_reset, 1, "hard reset");
    chk(o_vme_reset, vme, "vme reset");
    w = 0;
    v = 0;
    while (o_board_reset === 1'b1 && w < 20000) begin
      if (o_vme_reset === 1'b1) begin
        v++;
      end
      step(1);
      w++;
    end
    chk(16'(w), 16'(arbl_pkg::RST_CYC), "reset length");
    chk(16'(v), vme ? 16'(arbl_pkg::RST_CYC) : 16'h0000, "vme len");
    step(2);
    chk(o_fail_led, 1, "fail led");
    rdchk(arbl_pkg::ADDR_CTRL, arbl_pkg::CTRL_RST);
    chk(16'(n_abort - a0), 0, "abort on long press");
    $display("test long press done");
  endtask : long_press

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    #5_000_000;
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    i_clk_sys = 1'b0;
    i_rst_n = 1'b0;
    {i_wr, i_rd, go, i_link_f1, i_cpu_ready} = '0;
    {i_trigger_output, i_power_fail, i_addr, i_wdata, len} = '0;
    {i_speed_g1, i_speed_g2, i_quality_g1, i_quality_g2} = '0;
    {i_storage_act, i_activity} = '0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    step(1);
    chk(o_fail_led, 1, "fail led at reset");
    rdchk(arbl_pkg::ADDR_CTRL, 8'h01);
    rdchk(4'hf, 8'h00);
    wr(arbl_pkg::ADDR_CTRL, 8'h0e);
    step(2);
    chk(o_user_led, 3'h7, "user leds on");
    chk(o_fail_led, 0, "fail led cleared");
    wr(arbl_pkg::ADDR_CTRL, 8'h04);
    step(2);
    chk(o_user_led, 3'h2, "one user led");
    for (k = 0; k < 3; k++) begin
      s = 2'(k);
      @(posedge i_clk_sys);
      {i_speed_g1, i_speed_g2, i_link_f1} <= {s, s, s != 2'h0};
      {i_quality_g1, i_quality_g2} <= {s, s} | {4{s[1]}};
      step(2);
      chk({o_speed_green_led, o_speed_yellow_led},
          {{2{s == 2'h2}}, s != 2'h0, {2{s == 2'h1}}}, "speed");
      // Blink phases are still low this early, so only good is lit
      chk(o_link_quality_led, {2{s[1]}}, "quality");
      chk(o_link_activity_led, 3'h0, "idle activity");
    end
    rdchk(arbl_pkg::ADDR_LINK, 8'he8);
    for (k = 0; k < 8; k++) begin
      wr(arbl_pkg::ADDR_CTRL, k[2] ? 8'h10 : 8'h00);
      i_storage_act <= k[1:0];
      {i_cpu_ready, i_trigger_output} <= k[1:0];
      step(2);
      chk(o_storage_activity_led_a, k[2] ? k[0] : |k[1:0], "sa");
      chk(o_storage_activity_led_b, k[2] & k[1], "sb");
      chk(o_processor_ready_led, |k[1:0], "ready");
    end
    $display("test indicators done");
    wr(arbl_pkg::ADDR_MASK, 8'h03);
    i_power_fail <= 1'b1;
    step(2);
    chk(o_power_fail_led, 1, "power fail led");
    chk(o_irq, 1, "irq power fail");
    rdchk(arbl_pkg::ADDR_STAT, 8'h02);
    rdchk(arbl_pkg::ADDR_MASK, 8'h03);
    step(2);
    chk(o_irq, 0, "irq after read");
    press(16'h0014);
    k = 0;
    while (o_abort_irq !== 1'b1 && k < 100) begin
      step(1);
      k++;
    end
    chk(o_abort_irq, 1, "abort pulse");
    chk(o_board_reset, 0, "no reset on short press");
    step(2);
    chk(o_irq, 1, "irq abort");
    rdchk(arbl_pkg::ADDR_STAT, 8'h01);
    @(posedge i_clk_sys);
    i_power_fail <= 1'b0;
    $display("test short press done");
    long_press(8'h20, 1'b1);
    long_press(8'h00, 1'b0);
    finish_test();
  end
endmodule : testbench
